// file: verilog/pmc_power_ctrl.sv
// power mode controller: mode sequencing, clock and oscillator gating, wake-up handling
//
// Operation
// - five modes: normal, idle, stop, suspend, sleep, entered and left here
// - idle entered only after the instruction setting it finishes
// - idle keeps registers, memory and peripheral clocks alive
// - enabled interrupt in idle clears idle bit and resumes cpu
// - reset in idle runs reset sequence from address zero
// - watchdog keeps counting in idle and may end it by reset
// - stop halts cpu and precision oscillator after instruction ends
// - only a reset leaves stop, restarting at address zero
// - enabled missing clock detector reset ends stop; disable for long stops
// - suspend gates system clock and disables internal oscillators
// - suspend stops all digital logic until an enabled wake source
// - suspend wake sources individually enabled: rtc fail, alarm, match, comparator
// - wake flags read zero for two clocks after suspend wake; here they read zero for three
// - short reset pin glitch still ends suspend
// - config read shows whether last wake came from reset pin
// - sleep cuts core power, keeps rtc oscillator, comparator needs two-cell
// - writing one to sleep bit enters sleep; bit is write-only
// - entry refused while an enabled wake flag is set
`timescale 1ns/10ps
`include "pmc_map.svh"
module pmc_power_ctrl
  import pmc_pkg::*;
#(
  parameter int OSC_START_CYC = `PMC_OSC_START_CYC,
  parameter int RSTWK_HOLD    = `PMC_RSTWK_HOLD_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        instr_done,
  input  wire logic        pctl_wr,
  input  wire logic  [7:0] pctl_wdata,
  input  wire logic        cfg_wr,
  input  wire logic  [7:0] cfg_wdata,
  input  wire logic        irq_pending,
  input  wire logic        sys_rst_req,
  input  wire logic        wdt_enable,
  input  wire logic        mcd_enable,
  input  wire logic        prec_osc_cfg,
  input  wire logic        lp_osc_cfg,
  input  wire logic        ext_osc_cfg,
  input  wire logic        sysclk_is_prec,
  input  wire logic        two_cell_mode,
  input  wire logic        rtc_osc_fail,
  input  wire logic        rtc_alarm,
  input  wire logic        port_match,
  input  wire logic        cmp0_out,
  input  wire logic        rst_pin_n,
  output logic       [7:0] pctl_rdata,
  output logic       [7:0] cfg_rdata,
  output pmc_mode_t        power_mode,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             prec_osc_en,
  output logic             lp_osc_en,
  output logic             ext_osc_en,
  output logic             rtc_osc_en,
  output logic             core_pwr_en,
  output logic             wdt_run,
  output logic             mcd_run,
  output logic             cpu_rst_pulse,
  output logic      [15:0] reset_vector,
  output logic             resume_pulse,
  output logic             entry_refused,
  output logic             pin_wake_hold
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pmc_state_t  state_reg;
  pmc_state_t  state_next;
  logic        idle_sel_reg;
  logic        stop_sel_reg;
  logic [3:0]  wake_en_reg;
  logic        osc_was_prec_reg;
  logic [7:0]  osc_cnt_reg;
  logic        cpu_rst_reg;
  logic        resume_reg;
  logic        refused_reg;
  logic [7:0]  cfg_rdata_reg;
  logic [4:0]  flags;
  logic        flags_blank;
  logic        wake_done;
  logic        pin_wake_done;
  logic        low_req;
  logic        low_blocked;
  logic        wake_hit;
  logic [4:0]  en_mask;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // mask of flags that may end suspend or sleep; pin wake always armed
  function automatic logic [4:0] wake_mask(input logic [3:0] en,
                                           input logic       sleeping,
                                           input logic       two_cell);
    logic [4:0] m;
    m = {1'b1, en};
    if (sleeping && !two_cell) begin
      m[`PMC_CFG_CPT0WK_BIT] = 1'b0;
    end
    return m;
  endfunction

  function automatic logic is_low(input pmc_state_t s);
    return (s == PMC_ST_SUSPEND) || (s == PMC_ST_SLEEP);
  endfunction

  // ----------------------------------------------------------------
  // always-on flags and timers
  // ----------------------------------------------------------------
  pmc_wake_flags u_flags (
    .ref_clk      (ref_clk),
    .rst_n        (rst_n),
    .rtc_osc_fail (rtc_osc_fail),
    .rtc_alarm    (rtc_alarm),
    .port_match   (port_match),
    .cmp0_out     (cmp0_out),
    .rst_pin_n    (rst_pin_n),
    .flag_clear   (cfg_wr & cfg_wdata[`PMC_CFG_CLEAR_BIT]),
    .flags_reg    (flags)
  );

  assign wake_done = (state_reg == PMC_ST_OSC_START) && (osc_cnt_reg == 8'h00);

  pmc_hold_timer #(
    .CYCLES (`PMC_FLAG_BLANK_CYC),
    .W      (2)
  ) u_blank (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .start   (wake_done),
    .busy    (flags_blank)
  );

  assign pin_wake_done = wake_done & flags[`PMC_CFG_RSTWK_BIT];

  pmc_hold_timer #(
    .CYCLES (RSTWK_HOLD),
    .W      (12)
  ) u_pin_hold (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .start   (pin_wake_done),
    .busy    (pin_wake_hold)
  );

  // ----------------------------------------------------------------
  // low power requests
  // ----------------------------------------------------------------
  // sleep or suspend bit written
  assign low_req = cfg_wr && (state_reg == PMC_ST_NORMAL) &&
                   (cfg_wdata[`PMC_CFG_SLEEP_BIT] | cfg_wdata[`PMC_CFG_SUSPEND_BIT]);

  // refuse while an enabled flag stands
  assign low_blocked = |(flags & wake_mask(cfg_wdata[3:0],
                                           cfg_wdata[`PMC_CFG_SLEEP_BIT],
                                           two_cell_mode));

  assign en_mask  = wake_mask(wake_en_reg, state_reg == PMC_ST_SLEEP, two_cell_mode);
  assign wake_hit = |(flags & en_mask);

  // ----------------------------------------------------------------
  // mode sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PMC_ST_NORMAL: begin
        if (instr_done && idle_sel_reg) begin
          state_next = PMC_ST_IDLE;
        end else if (instr_done && stop_sel_reg) begin
          state_next = PMC_ST_STOP;
        end else if (low_req && !low_blocked) begin
          state_next = cfg_wdata[`PMC_CFG_SLEEP_BIT] ? PMC_ST_SLEEP : PMC_ST_SUSPEND;
        end
      end
      PMC_ST_IDLE: begin
        if (irq_pending) begin
          state_next = PMC_ST_NORMAL;
        end
      end
      PMC_ST_STOP: begin
        state_next = PMC_ST_STOP;
      end
      PMC_ST_SUSPEND, PMC_ST_SLEEP: begin
        if (wake_hit) begin
          state_next = PMC_ST_OSC_START;
        end
      end
      PMC_ST_OSC_START: begin
        if (osc_cnt_reg == 8'h00) begin
          state_next = PMC_ST_NORMAL;
        end
      end
      default: begin
        state_next = PMC_ST_NORMAL;
      end
    endcase
    if (sys_rst_req) begin
      state_next = PMC_ST_NORMAL;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= PMC_ST_NORMAL;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // processor power control select bits
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_sel_reg <= 1'b0;
      stop_sel_reg <= 1'b0;
    end else if (sys_rst_req) begin
      idle_sel_reg <= 1'b0;
      stop_sel_reg <= 1'b0;
    end else if (pctl_wr) begin
      idle_sel_reg <= pctl_wdata[`PMC_PCTL_IDLE_BIT];
      stop_sel_reg <= pctl_wdata[`PMC_PCTL_STOP_BIT];
    end else if (state_reg == PMC_ST_IDLE && irq_pending) begin
      idle_sel_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // wake enables and oscillator memory
  // ----------------------------------------------------------------
  // enables drop after every wake so each entry must rewrite them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_en_reg <= `PMC_WAKE_EN_RESET;
    end else if (cfg_wr) begin
      // enables taken from the entry write
      wake_en_reg <= cfg_wdata[3:0];
    end else if (wake_done || sys_rst_req) begin
      wake_en_reg <= `PMC_WAKE_EN_RESET;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_was_prec_reg <= 1'b0;
    end else if (low_req && !low_blocked) begin
      osc_was_prec_reg <= sysclk_is_prec;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt_reg <= 8'h00;
    end else if (is_low(state_reg) && wake_hit) begin
      osc_cnt_reg <= 8'(OSC_START_CYC);
    end else if (osc_cnt_reg != 8'h00) begin
      osc_cnt_reg <= osc_cnt_reg - 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // event pulses
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_rst_reg <= 1'b0;
      resume_reg  <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      // watchdog reset arrives on the reset request
      cpu_rst_reg <= sys_rst_req;
      resume_reg  <= !sys_rst_req &&
                     (wake_done || (state_reg == PMC_ST_IDLE && irq_pending));
      refused_reg <= low_req && low_blocked;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // pin wake flag readable
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata_reg <= `PMC_CFG_RESET;
    end else if (flags_blank || wake_done) begin
      cfg_rdata_reg <= 8'h00;
    end else begin
      cfg_rdata_reg <= {3'b000, flags};
    end
  end

  assign cfg_rdata  = cfg_rdata_reg;
  assign pctl_rdata = {6'b000000, stop_sel_reg, idle_sel_reg};

  // ----------------------------------------------------------------
  // clock, oscillator and power gating
  // ----------------------------------------------------------------
  always_comb begin
    cpu_clk_en    = 1'b1;
    periph_clk_en = 1'b1;
    prec_osc_en   = prec_osc_cfg;
    lp_osc_en     = lp_osc_cfg;
    ext_osc_en    = ext_osc_cfg;
    core_pwr_en   = 1'b1;
    power_mode    = PMC_MODE_NORMAL;
    unique case (state_reg)
      PMC_ST_NORMAL: begin
        power_mode = PMC_MODE_NORMAL;
      end
      PMC_ST_IDLE: begin
        cpu_clk_en = 1'b0;
        power_mode = PMC_MODE_IDLE;
      end
      PMC_ST_STOP: begin
        cpu_clk_en    = 1'b0;
        periph_clk_en = 1'b0;
        prec_osc_en   = 1'b0;
        power_mode    = PMC_MODE_STOP;
      end
      PMC_ST_SUSPEND: begin
        cpu_clk_en    = 1'b0;
        periph_clk_en = 1'b0;
        prec_osc_en   = 1'b0;
        lp_osc_en     = 1'b0;
        power_mode    = PMC_MODE_SUSPEND;
      end
      PMC_ST_SLEEP: begin
        cpu_clk_en    = 1'b0;
        periph_clk_en = 1'b0;
        prec_osc_en   = 1'b0;
        lp_osc_en     = 1'b0;
        ext_osc_en    = 1'b0;
        core_pwr_en   = 1'b0;
        power_mode    = PMC_MODE_SLEEP;
      end
      PMC_ST_OSC_START: begin
        cpu_clk_en    = 1'b0;
        periph_clk_en = 1'b0;
        prec_osc_en   = osc_was_prec_reg;
        lp_osc_en     = !osc_was_prec_reg;
        power_mode    = PMC_MODE_NORMAL;
      end
    endcase
  end

  assign rtc_osc_en    = 1'b1;
  assign wdt_run       = wdt_enable && (state_reg == PMC_ST_NORMAL || state_reg == PMC_ST_IDLE);
  assign mcd_run       = mcd_enable && !is_low(state_reg) && (state_reg != PMC_ST_OSC_START);
  assign cpu_rst_pulse = cpu_rst_reg;
  assign reset_vector  = `PMC_RESET_VECTOR;
  assign resume_pulse  = resume_reg;
  assign entry_refused = refused_reg;
endmodule

// file: include/pmc_map.svh
// register bit positions, reset values and timing counts of the power mode controller
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

// ----------------------------------------------------------------
// processor power control bits
// ----------------------------------------------------------------
`define PMC_PCTL_IDLE_BIT    0
`define PMC_PCTL_STOP_BIT    1

// ----------------------------------------------------------------
// power unit config fields
// ----------------------------------------------------------------
`define PMC_CFG_SLEEP_BIT    7
`define PMC_CFG_SUSPEND_BIT  6
`define PMC_CFG_CLEAR_BIT    5
`define PMC_CFG_RSTWK_BIT    4
`define PMC_CFG_RTCFWK_BIT   3
`define PMC_CFG_RTCAWK_BIT   2
`define PMC_CFG_PMATWK_BIT   1
`define PMC_CFG_CPT0WK_BIT   0
`define PMC_CFG_RESET        8'h00
`define PMC_WAKE_EN_RESET    4'h0

// ----------------------------------------------------------------
// reset vector and timing
// ----------------------------------------------------------------
`define PMC_RESET_VECTOR     16'h0000
`define PMC_FLAG_BLANK_CYC   2
`define PMC_CLK_PERIOD_PS    25000
`define PMC_RSTWK_HOLD_NS    15
`define PMC_RSTWK_HOLD_CYC   ((`PMC_RSTWK_HOLD_NS * 1000000 + `PMC_CLK_PERIOD_PS - 1) / `PMC_CLK_PERIOD_PS)
`define PMC_OSC_START_CYC    4

`endif

// file: include/pmc_pkg.sv
// types shared by the power mode controller
package pmc_pkg;

  typedef enum logic [2:0] {
    PMC_ST_NORMAL,
    PMC_ST_IDLE,
    PMC_ST_STOP,
    PMC_ST_SUSPEND,
    PMC_ST_SLEEP,
    PMC_ST_OSC_START
  } pmc_state_t;

  typedef enum logic [2:0] {
    PMC_MODE_NORMAL,
    PMC_MODE_IDLE,
    PMC_MODE_STOP,
    PMC_MODE_SUSPEND,
    PMC_MODE_SLEEP
  } pmc_mode_t;

endpackage

// file: verilog/pmc_hold_timer.sv
// retriggerable down-counter that stands busy for a fixed number of cycles
`timescale 1ns/10ps
module pmc_hold_timer #(
  parameter int CYCLES = 2,
  parameter int W      = 12
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      busy
);
  logic [W-1:0] cnt_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (start) begin
      cnt_reg <= W'(CYCLES);
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - W'(1);
    end
  end

  assign busy = (cnt_reg != '0);
endmodule

// file: verilog/pmc_wake_flags.sv
// always-on wake-up flag latches with edge detection on comparator and reset pin
`timescale 1ns/10ps
module pmc_wake_flags (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       rtc_osc_fail,
  input  wire logic       rtc_alarm,
  input  wire logic       port_match,
  input  wire logic       cmp0_out,
  input  wire logic       rst_pin_n,
  input  wire logic       flag_clear,
  output logic      [4:0] flags_reg
);
  `include "pmc_map.svh"

  logic       cmp0_prev_reg;
  logic       pin_prev_reg;
  logic [4:0] event_vec;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp0_prev_reg <= 1'b0;
      pin_prev_reg  <= 1'b1;
    end else begin
      cmp0_prev_reg <= cmp0_out;
      pin_prev_reg  <= rst_pin_n;
    end
  end

  // a short low pulse on the pin still counts: any falling edge
  always_comb begin
    event_vec                      = '0;
    event_vec[`PMC_CFG_RSTWK_BIT]  = pin_prev_reg & ~rst_pin_n;
    event_vec[`PMC_CFG_RTCFWK_BIT] = rtc_osc_fail;
    event_vec[`PMC_CFG_RTCAWK_BIT] = rtc_alarm;
    event_vec[`PMC_CFG_PMATWK_BIT] = port_match;
    event_vec[`PMC_CFG_CPT0WK_BIT] = cmp0_out & ~cmp0_prev_reg;
  end

  // always-on sticky flags
  // set beats clear so an event in the clearing cycle survives
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= 5'h00;
    end else begin
      flags_reg <= (flag_clear ? 5'h00 : flags_reg) | event_vec;
    end
  end
endmodule

// file: sim/pmc_power_ctrl_asserts.sv
// assertion checker for the power mode controller ports
`timescale 1ns/10ps
`include "pmc_map.svh"
module pmc_power_ctrl_asserts
  import pmc_pkg::*;
#(
  parameter int OSC_START_CYC = `PMC_OSC_START_CYC,
  parameter int RSTWK_HOLD    = `PMC_RSTWK_HOLD_CYC
) (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        instr_done,
  input wire logic        irq_pending,
  input wire logic        sys_rst_req,
  input wire logic        wdt_enable,
  input wire logic        lp_osc_cfg,
  input wire logic        ext_osc_cfg,
  input wire logic        cfg_wr,
  input wire logic  [7:0] cfg_wdata,
  input wire logic        rst_pin_n,
  input wire logic  [7:0] pctl_rdata,
  input wire logic  [7:0] cfg_rdata,
  input wire pmc_mode_t   power_mode,
  input wire logic        cpu_clk_en,
  input wire logic        periph_clk_en,
  input wire logic        prec_osc_en,
  input wire logic        lp_osc_en,
  input wire logic        ext_osc_en,
  input wire logic        rtc_osc_en,
  input wire logic        core_pwr_en,
  input wire logic        wdt_run,
  input wire logic        cpu_rst_pulse,
  input wire logic [15:0] reset_vector,
  input wire logic        resume_pulse,
  input wire logic        entry_refused
);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  logic was_susp_reg;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // remembers a suspend until the cpu clock returns
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      was_susp_reg <= 1'b0;
    end else if (power_mode == PMC_MODE_SUSPEND) begin
      was_susp_reg <= 1'b1;
    end else if (cpu_clk_en) begin
      was_susp_reg <= 1'b0;
    end
  end
  sequence s_resume;
    (power_mode == PMC_MODE_NORMAL && resume_pulse) ##1 !resume_pulse;
  endsequence
  sequence s_flags_blank;
    (cfg_rdata[4:0] == 5'h00) [*2];
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_idle_entry: assert property (
    pctl_rdata[0] && instr_done && cpu_clk_en && !sys_rst_req |=> power_mode == PMC_MODE_IDLE)
    else $error("idle not entered at instruction end");
  a_idle_clocks: assert property (
    power_mode == PMC_MODE_IDLE |-> !cpu_clk_en && periph_clk_en && wdt_run == wdt_enable)
    else $error("idle clocks wrong");
  a_idle_wake: assert property (
    power_mode == PMC_MODE_IDLE && irq_pending && !sys_rst_req |=> s_resume)
    else $error("interrupt did not resume cpu");
  a_stop_hold: assert property (
    power_mode == PMC_MODE_STOP && !sys_rst_req |=> power_mode == PMC_MODE_STOP)
    else $error("stop left without reset");
  a_stop_osc: assert property (
    power_mode == PMC_MODE_STOP |-> !prec_osc_en && !cpu_clk_en
      && lp_osc_en == lp_osc_cfg && ext_osc_en == ext_osc_cfg)
    else $error("stop oscillators wrong");
  a_reset_exit: assert property (
    sys_rst_req |=> cpu_rst_pulse && power_mode == PMC_MODE_NORMAL && reset_vector == 16'h0000)
    else $error("reset did not restart cpu");
  a_susp_gate: assert property (
    power_mode == PMC_MODE_SUSPEND |-> !cpu_clk_en && !periph_clk_en && !prec_osc_en && !lp_osc_en)
    else $error("suspend clocks not gated");
  a_sleep_power: assert property (
    power_mode == PMC_MODE_SLEEP |-> !core_pwr_en && rtc_osc_en && !prec_osc_en
      && !lp_osc_en && !ext_osc_en)
    else $error("sleep power wrong");
  a_flag_blank: assert property (
    was_susp_reg && cpu_clk_en |=> s_flags_blank)
    else $error("flags not blank after wake");
  a_refuse_entry: assert property (
    cfg_wr && cfg_wdata[6] && !cfg_wdata[7] && power_mode == PMC_MODE_NORMAL && cpu_clk_en
      && ((cfg_wdata[3:0] & cfg_rdata[3:0]) != 4'h0 || cfg_rdata[4]) |=> entry_refused)
    else $error("entry with enabled flag set");
  a_pin_wake: assert property (
    power_mode == PMC_MODE_SUSPEND && $fell(rst_pin_n) |-> ##[1:40] cpu_clk_en)
    else $error("pin glitch did not wake");
endmodule
bind pmc_power_ctrl pmc_power_ctrl_asserts #(
  .OSC_START_CYC(OSC_START_CYC), .RSTWK_HOLD(RSTWK_HOLD)
) u_asserts (
  .ref_clk(ref_clk), .rst_n(rst_n), .instr_done(instr_done), .irq_pending(irq_pending),
  .sys_rst_req(sys_rst_req), .wdt_enable(wdt_enable), .lp_osc_cfg(lp_osc_cfg),
  .ext_osc_cfg(ext_osc_cfg), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .rst_pin_n(rst_pin_n),
  .pctl_rdata(pctl_rdata), .cfg_rdata(cfg_rdata), .power_mode(power_mode),
  .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .prec_osc_en(prec_osc_en),
  .lp_osc_en(lp_osc_en), .ext_osc_en(ext_osc_en), .rtc_osc_en(rtc_osc_en),
  .core_pwr_en(core_pwr_en), .wdt_run(wdt_run), .cpu_rst_pulse(cpu_rst_pulse),
  .reset_vector(reset_vector), .resume_pulse(resume_pulse), .entry_refused(entry_refused)
);

// file: sim/pmc_power_ctrl_test.sv
// self-checking bench for the power mode controller
`timescale 1ns/10ps
module pmc_power_ctrl_test
  import pmc_pkg::*;
();
  // ----------------------------------------
  // signals and design
  // ----------------------------------------
  localparam int HOLD_CYC = 8;
  logic        ref_clk, rst_n, instr_done, pctl_wr, cfg_wr, irq_pending, sys_rst_req;
  logic        wdt_enable, mcd_enable, prec_osc_cfg, lp_osc_cfg, ext_osc_cfg, sysclk_is_prec;
  logic        two_cell_mode, rtc_osc_fail, rtc_alarm, port_match, cmp0_out, rst_pin_n;
  logic  [7:0] pctl_wdata, cfg_wdata, pctl_rdata, cfg_rdata;
  logic [15:0] reset_vector;
  pmc_mode_t   power_mode;
  logic        cpu_clk_en, periph_clk_en, prec_osc_en, lp_osc_en, ext_osc_en, rtc_osc_en;
  logic        core_pwr_en, wdt_run, mcd_run, cpu_rst_pulse, resume_pulse, entry_refused;
  logic        pin_wake_hold;
  int          err_total, cmp_count;

  // short oscillator start and pin hold keep the run brief
  pmc_power_ctrl #(.OSC_START_CYC(1), .RSTWK_HOLD(HOLD_CYC)) uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .instr_done(instr_done), .pctl_wr(pctl_wr),
    .pctl_wdata(pctl_wdata), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .irq_pending(irq_pending),
    .sys_rst_req(sys_rst_req), .wdt_enable(wdt_enable), .mcd_enable(mcd_enable),
    .prec_osc_cfg(prec_osc_cfg), .lp_osc_cfg(lp_osc_cfg), .ext_osc_cfg(ext_osc_cfg),
    .sysclk_is_prec(sysclk_is_prec), .two_cell_mode(two_cell_mode),
    .rtc_osc_fail(rtc_osc_fail), .rtc_alarm(rtc_alarm), .port_match(port_match),
    .cmp0_out(cmp0_out), .rst_pin_n(rst_pin_n), .pctl_rdata(pctl_rdata), .cfg_rdata(cfg_rdata),
    .power_mode(power_mode), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .prec_osc_en(prec_osc_en), .lp_osc_en(lp_osc_en), .ext_osc_en(ext_osc_en),
    .rtc_osc_en(rtc_osc_en), .core_pwr_en(core_pwr_en), .wdt_run(wdt_run), .mcd_run(mcd_run),
    .cpu_rst_pulse(cpu_rst_pulse), .reset_vector(reset_vector), .resume_pulse(resume_pulse),
    .entry_refused(entry_refused), .pin_wake_hold(pin_wake_hold)
  );
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic wr_pctl(input logic [7:0] d);
    pctl_wr    = 1'b1;
    pctl_wdata = d;
    step(1);
    pctl_wr    = 1'b0;
    step(1);
  endtask
  task automatic end_instr();
    instr_done = 1'b1;
    step(1);
    instr_done = 1'b0;
  endtask
  // leaves cfg_wr low at the edge after capture; caller steps before the next write
  task automatic wr_cfg(input logic [7:0] d);
    cfg_wr    = 1'b1;
    cfg_wdata = d;
    step(1);
    cfg_wr    = 1'b0;
  endtask
  task automatic wait_wake();
    int i;
    i = 0;
    while (cpu_clk_en !== 1'b1 && i < 50) begin
      step(1);
      i++;
    end
    check(cpu_clk_en, 1, "wake");
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_idle();
    wr_pctl(8'h01);
    check(pctl_rdata, 8'h01, "idle sel");
    step(2);
    check(power_mode, PMC_MODE_NORMAL, "early idle");
    end_instr();
    check(power_mode, PMC_MODE_IDLE, "idle");
    check({cpu_clk_en, periph_clk_en}, 2'b01, "idle clk");
    check(wdt_run, 1, "wdt in idle");
    irq_pending = 1'b1;
    step(1);
    irq_pending = 1'b0;
    check({power_mode, pctl_rdata}, {PMC_MODE_NORMAL, 8'h00}, "irq exit");
    check(resume_pulse, 1, "resume");
    step(1);
    wr_pctl(8'h01);
    end_instr();
    sys_rst_req = 1'b1;
    step(1);
    sys_rst_req = 1'b0;
    check({cpu_rst_pulse, power_mode}, {1'b1, PMC_MODE_NORMAL}, "idle reset");
    check(reset_vector, 16'h0000, "vector");
  endtask
  task automatic t_stop();
    wr_pctl(8'h02);
    end_instr();
    check(power_mode, PMC_MODE_STOP, "stop");
    check({cpu_clk_en, prec_osc_en, lp_osc_en, ext_osc_en}, 4'h3, "stop osc");
    check(mcd_run, 1, "mcd in stop");
    irq_pending = 1'b1;
    step(3);
    irq_pending = 1'b0;
    check(power_mode, PMC_MODE_STOP, "irq in stop");
    sys_rst_req = 1'b1;
    step(1);
    sys_rst_req = 1'b0;
    check({cpu_rst_pulse, power_mode}, {1'b1, PMC_MODE_NORMAL}, "stop reset");
  endtask
  task automatic t_source(input int s);
    wr_cfg(8'h20);
    step(1);
    wr_cfg(8'h40 | (8'h01 << s));
    check(power_mode, PMC_MODE_SUSPEND, "suspend");
    check({cpu_clk_en, periph_clk_en, prec_osc_en, lp_osc_en}, 4'h0, "gated");
    step(1);
    {rtc_osc_fail, rtc_alarm, port_match, cmp0_out} = 4'h1 << s;
    step(1);
    {rtc_osc_fail, rtc_alarm, port_match, cmp0_out} = 4'h0;
    wait_wake();
    check(prec_osc_en, 1, "osc back");
    check({resume_pulse, cfg_rdata}, 9'h100, "blank 1");
    step(1);
    check(cfg_rdata, 8'h00, "blank 2");
    step(5);
    check(cfg_rdata, 8'h01 << s, "flag");
  endtask
  task automatic t_refuse();
    wr_cfg(8'h48);
    check({entry_refused, power_mode}, {1'b1, PMC_MODE_NORMAL}, "refuse");
    step(1);
    wr_cfg(8'h44);
    check(power_mode, PMC_MODE_SUSPEND, "masked flag");
    step(1);
    rtc_alarm = 1'b1;
    step(1);
    rtc_alarm = 1'b0;
    wait_wake();
  endtask
  task automatic t_pin();
    wr_cfg(8'h20);
    step(1);
    wr_cfg(8'h40);
    step(1);
    rst_pin_n = 1'b0;
    step(1);
    rst_pin_n = 1'b1;
    wait_wake();
    check(pin_wake_hold, 1, "pin hold");
    step(6);
    check(cfg_rdata, 8'h10, "pin flag");
    wr_cfg(8'h40);
    check(entry_refused, 1, "pin blocks");
    step(HOLD_CYC + 10);
    check(pin_wake_hold, 0, "hold end");
  endtask
  task automatic t_sleep();
    wr_cfg(8'h20);
    step(1);
    two_cell_mode = 1'b1;
    wr_cfg(8'h81);
    check({power_mode, core_pwr_en, rtc_osc_en}, {PMC_MODE_SLEEP, 2'b01}, "sleep");
    check({prec_osc_en, lp_osc_en, ext_osc_en}, 3'h0, "sleep osc");
    step(1);
    cmp0_out = 1'b1;
    step(1);
    cmp0_out = 1'b0;
    wait_wake();
    wr_cfg(8'h20);
    step(1);
    two_cell_mode = 1'b0;
    wr_cfg(8'h81);
    step(1);
    cmp0_out = 1'b1;
    step(4);
    check(power_mode, PMC_MODE_SLEEP, "one cell cmp");
    cmp0_out  = 1'b0;
    rst_pin_n = 1'b0;
    step(1);
    rst_pin_n = 1'b1;
    wait_wake();
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    finish_test();
  end
  initial begin
    {rst_n, instr_done, pctl_wr, cfg_wr, irq_pending, sys_rst_req, two_cell_mode} = 7'h0;
    {rtc_osc_fail, rtc_alarm, port_match, cmp0_out, pctl_wdata, cfg_wdata} = 20'h0;
    {wdt_enable, mcd_enable, prec_osc_cfg, lp_osc_cfg, ext_osc_cfg} = 5'h1f;
    {sysclk_is_prec, rst_pin_n} = 2'h3;
    err_total = 0;
    cmp_count = 0;
    step(11);
    rst_n = 1'b1;
    step(1);
    t_idle();
    t_stop();
    for (int s = 0; s < 4; s++) begin
      t_source(s);
    end
    t_refuse();
    t_pin();
    t_sleep();
    finish_test();
  end
endmodule
